// file: logic/slpc_regs.vh
// slpc_regs.vh: latch field positions, select codes, reset values and timing.
// assumes inclusion by slpc_top only; definitions only.
`ifndef SLPC_REGS_VH
`define SLPC_REGS_VH
`define SLPC_WORD_W          24
`define SLPC_SEL_CONTROL     2'b00
`define SLPC_SEL_REFERENCE   2'b01
`define SLPC_SEL_DIVIDER     2'b10
`define SLPC_SEL_TEST        2'b11
// divider latch fields
`define SLPC_DIV_HALVSEL_BIT 23
`define SLPC_DIV_HALVEN_BIT  22
`define SLPC_DIV_GAIN_BIT    21
`define SLPC_DIV_B_MSB       20
`define SLPC_DIV_B_LSB       8
`define SLPC_DIV_A_MSB       6
`define SLPC_DIV_A_LSB       2
// reference latch fields
`define SLPC_REF_BAND_MSB    21
`define SLPC_REF_BAND_LSB    20
`define SLPC_REF_TEST_BIT    19
`define SLPC_REF_LDP_BIT     18
`define SLPC_REF_ABP_MSB     17
`define SLPC_REF_ABP_LSB     16
`define SLPC_REF_R_MSB       15
`define SLPC_REF_R_LSB       2
// control latch fields
`define SLPC_CTL_PRE_MSB     23
`define SLPC_CTL_PRE_LSB     22
`define SLPC_CTL_PDSYNC_BIT  21
`define SLPC_CTL_PDREQ_BIT   20
`define SLPC_CTL_CURB_MSB    19
`define SLPC_CTL_CURB_LSB    17
`define SLPC_CTL_CURA_MSB    16
`define SLPC_CTL_CURA_LSB    14
`define SLPC_CTL_LVL_MSB     13
`define SLPC_CTL_LVL_LSB     12
`define SLPC_CTL_MUTE_BIT    11
`define SLPC_CTL_GAIN_BIT    10
// reset values
`define SLPC_LATCH_RST       24'h000000
// timing
`define SLPC_MCLK_HZ         20000000
`define SLPC_PD_SYNC_EDGES   2'd2
`endif

// file: logic/slpc_sync2.v
// slpc_sync2.v: two-flop synchroniser for one pin level.
// assumes the input is asynchronous to mclk.
`timescale 1ns/1ps
module slpc_sync2 #(
   parameter RST_VAL = 1'b0
) (
   input  wire mclk,
   input  wire nrst,
   input  wire pin_in,
   output reg  sync_out
);
   reg meta_q;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         meta_q   <= RST_VAL;
         sync_out <= RST_VAL;
      end else begin
         meta_q   <= pin_in;
         sync_out <= meta_q;
      end
   end
endmodule // slpc_sync2

// file: logic/slpc_edge.v
// slpc_edge.v: rising edge pulse from a synchronised level.
// assumes the input already lives in the mclk domain.
`timescale 1ns/1ps
module slpc_edge (
   input  wire mclk,
   input  wire nrst,
   input  wire lvl,
   output wire rise
);
   reg prev_q;
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         prev_q <= 1'b0;
      end else begin
         prev_q <= lvl;
      end
   end
   assign rise = lvl & ~prev_q;
endmodule // slpc_edge

// file: logic/slpc_top.v
// slpc_top.v: three-wire configuration latches and power-down control.
// assumes serial pins, chip enable, reference output and lock come from outside mclk.
//
// Function
// - host shifts 24 bits msb first on clock rise; latch strobe rise transfers
// - select bits 00 load the control latch
// - select bits 10 load the divider latch with a and b counts
// - select bits 01 load the reference divider latch
// - divider latch: halving select, halving enable, gain, b count, reserved, a count
// - reference latch: band clock div, test flag, lock precision, antibacklash, r count
// - first control load with request clear powers the device up
// - request set with sync select clear powers down immediately on latching
// - request and sync select set: power down on second reference edge
// - chip enable low disables the device at once
// - power-down loads counters, three-states pump, resets lock, mutes outputs
// - serial input keeps shifting and latching while powered down
// - mute-until-locked keeps the rf output off until lock
// - gain bit one selects current setting b, zero setting a
// - gain bit follows whichever latch wrote it last
// - current a from low three bits, current b from high three bits
// - two control bits select the prescaler ratio
// - two control bits select one of four output levels
`timescale 1ns/1ps
`include "slpc_regs.vh"
module slpc_top #(
   parameter WORD_W = `SLPC_WORD_W
) (
   input  wire              mclk,
   input  wire              nrst,
   input  wire              ser_clk,
   input  wire              ser_data,
   input  wire              latch_strobe,
   input  wire              chip_enable,
   input  wire              ref_div_out,
   input  wire              loop_locked,
   output reg               powered_q,
   output reg               counters_load_q,
   output reg               pump_tristate_q,
   output reg               lock_reset_q,
   output reg               rf_out_enable_q,
   output reg               ref_buf_enable_q,
   output reg               prescaler_input_halving_sel,
   output reg               output_halving_enable,
   output reg               pump_gain_select,
   output reg  [12:0]       b_count,
   output reg  [4:0]        a_count,
   output reg  [1:0]        band_clk_div,
   output reg               factory_test_flag,
   output reg               lock_precision_sel,
   output reg  [1:0]        antibacklash_width,
   output reg  [13:0]       ref_count,
   output reg  [1:0]        prescaler_sel,
   output reg  [2:0]        pump_current_a,
   output reg  [2:0]        pump_current_b,
   output reg  [2:0]        pump_current,
   output reg  [1:0]        out_level,
   output reg               mute_until_locked,
   output reg               divider_written_q
);
   localparam ST_OFF   = 2'd0;
   localparam ST_ON    = 2'd1;
   localparam ST_WAIT  = 2'd2;
   localparam ST_PDOWN = 2'd3;

   wire              clk_s;
   wire              data_s;
   wire              strobe_s;
   wire              ce_s;
   wire              ref_s;
   wire              lock_s;
   wire              clk_rise;
   wire              strobe_rise;
   wire              ref_rise;
   reg  [WORD_W-1:0] shift_q;
   reg  [WORD_W-1:0] ctl_q;
   reg  [1:0]        st_q;
   reg  [1:0]        st_d;
   reg  [1:0]        ref_cnt_q;
   reg  [1:0]        ref_cnt_d;
   reg               gain_q;
   reg               gain_d;
   wire [1:0]        sel;
   wire              ld_ctl;
   wire              ld_ref;
   wire              ld_div;
   wire              on_d;

   // pins cross into mclk before any logic looks at them
   slpc_sync2 #(
      .RST_VAL  (1'b0)
   ) u_sclk (
      .mclk     (mclk),
      .nrst     (nrst),
      .pin_in   (ser_clk),
      .sync_out (clk_s)
   );
   slpc_sync2 #(
      .RST_VAL  (1'b0)
   ) u_sdat (
      .mclk     (mclk),
      .nrst     (nrst),
      .pin_in   (ser_data),
      .sync_out (data_s)
   );
   slpc_sync2 #(
      .RST_VAL  (1'b0)
   ) u_sle (
      .mclk     (mclk),
      .nrst     (nrst),
      .pin_in   (latch_strobe),
      .sync_out (strobe_s)
   );
   slpc_sync2 #(
      .RST_VAL  (1'b0)
   ) u_ce (
      .mclk     (mclk),
      .nrst     (nrst),
      .pin_in   (chip_enable),
      .sync_out (ce_s)
   );
   slpc_sync2 #(
      .RST_VAL  (1'b0)
   ) u_ref (
      .mclk     (mclk),
      .nrst     (nrst),
      .pin_in   (ref_div_out),
      .sync_out (ref_s)
   );
   slpc_sync2 #(
      .RST_VAL  (1'b0)
   ) u_lock (
      .mclk     (mclk),
      .nrst     (nrst),
      .pin_in   (loop_locked),
      .sync_out (lock_s)
   );

   slpc_edge u_clk_e (
      .mclk (mclk),
      .nrst (nrst),
      .lvl  (clk_s),
      .rise (clk_rise)
   );
   slpc_edge u_le_e (
      .mclk (mclk),
      .nrst (nrst),
      .lvl  (strobe_s),
      .rise (strobe_rise)
   );
   slpc_edge u_ref_e (
      .mclk (mclk),
      .nrst (nrst),
      .lvl  (ref_s),
      .rise (ref_rise)
   );

   // serial clock must stay under a quarter of mclk for the sampler to see it
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         shift_q <= `SLPC_LATCH_RST;
      end else if (clk_rise) begin
         shift_q <= {shift_q[WORD_W-2:0], data_s};
      end
   end

   assign sel    = shift_q[1:0];
   assign ld_ctl = strobe_rise && (sel == `SLPC_SEL_CONTROL);
   assign ld_ref = strobe_rise && (sel == `SLPC_SEL_REFERENCE);
   assign ld_div = strobe_rise && (sel == `SLPC_SEL_DIVIDER);

   // test latch writes are dropped: no user function behind them
   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         ctl_q                       <= `SLPC_LATCH_RST;
         prescaler_input_halving_sel <= 1'b0;
         output_halving_enable       <= 1'b0;
         b_count                     <= 13'h0000;
         a_count                     <= 5'h00;
         band_clk_div                <= 2'h0;
         factory_test_flag           <= 1'b0;
         lock_precision_sel          <= 1'b0;
         antibacklash_width          <= 2'h0;
         ref_count                   <= 14'h0000;
         divider_written_q           <= 1'b0;
      end else begin
         if (ld_ctl) begin
            ctl_q <= shift_q;
         end
         if (ld_div) begin
            prescaler_input_halving_sel <= shift_q[`SLPC_DIV_HALVSEL_BIT];
            output_halving_enable       <= shift_q[`SLPC_DIV_HALVEN_BIT];
            b_count   <= shift_q[`SLPC_DIV_B_MSB:`SLPC_DIV_B_LSB];
            a_count   <= shift_q[`SLPC_DIV_A_MSB:`SLPC_DIV_A_LSB];
            divider_written_q <= 1'b1;
         end
         if (ld_ref) begin
            band_clk_div       <= shift_q[`SLPC_REF_BAND_MSB:`SLPC_REF_BAND_LSB];
            factory_test_flag  <= shift_q[`SLPC_REF_TEST_BIT];
            lock_precision_sel <= shift_q[`SLPC_REF_LDP_BIT];
            antibacklash_width <= shift_q[`SLPC_REF_ABP_MSB:`SLPC_REF_ABP_LSB];
            ref_count          <= shift_q[`SLPC_REF_R_MSB:`SLPC_REF_R_LSB];
         end
      end
   end

   // shared gain bit, last writer wins
   always @* begin
      gain_d = gain_q;
      if (ld_ctl) begin
         gain_d = shift_q[`SLPC_CTL_GAIN_BIT];
      end else if (ld_div) begin
         gain_d = shift_q[`SLPC_DIV_GAIN_BIT];
      end
   end

   // power state machine
   always @* begin
      st_d      = st_q;
      ref_cnt_d = ref_cnt_q;
      case (st_q)
         ST_OFF: begin
            if (ld_ctl && !shift_q[`SLPC_CTL_PDREQ_BIT]) begin
               st_d = ST_ON;
            end
         end
         ST_ON: begin
            if (ld_ctl && shift_q[`SLPC_CTL_PDREQ_BIT]) begin
               if (shift_q[`SLPC_CTL_PDSYNC_BIT]) begin
                  st_d      = ST_WAIT;
                  ref_cnt_d = 2'd0;
               end else begin
                  st_d = ST_PDOWN;
               end
            end
         end
         ST_WAIT: begin
            if (ld_ctl && !shift_q[`SLPC_CTL_PDREQ_BIT]) begin
               st_d = ST_ON;
            end else if (ld_ctl && !shift_q[`SLPC_CTL_PDSYNC_BIT]) begin
               st_d = ST_PDOWN;
            end else if (ld_ctl) begin
               // a fresh sync request counts its edges from its own strobe
               ref_cnt_d = 2'd0;
            end else if (ref_rise) begin
               ref_cnt_d = ref_cnt_q + 2'd1;
               if (ref_cnt_q == (`SLPC_PD_SYNC_EDGES - 2'd1)) begin
                  st_d = ST_PDOWN;
               end
            end
         end
         ST_PDOWN: begin
            if (ld_ctl && !shift_q[`SLPC_CTL_PDREQ_BIT]) begin
               st_d = ST_ON;
            end
         end
         default: begin
            st_d = ST_OFF;
         end
      endcase
   end

   // chip enable overrides the programmed state
   assign on_d = ce_s && (st_d == ST_ON || st_d == ST_WAIT);

   always @(posedge mclk or negedge nrst) begin
      if (!nrst) begin
         st_q               <= ST_OFF;
         ref_cnt_q          <= 2'd0;
         gain_q             <= 1'b0;
         powered_q          <= 1'b0;
         counters_load_q    <= 1'b1;
         pump_tristate_q    <= 1'b1;
         lock_reset_q       <= 1'b1;
         rf_out_enable_q    <= 1'b0;
         ref_buf_enable_q   <= 1'b0;
         pump_gain_select   <= 1'b0;
         prescaler_sel      <= 2'h0;
         pump_current_a     <= 3'h0;
         pump_current_b     <= 3'h0;
         pump_current       <= 3'h0;
         out_level          <= 2'h0;
         mute_until_locked  <= 1'b0;
      end else begin
         st_q             <= st_d;
         ref_cnt_q        <= ref_cnt_d;
         gain_q           <= gain_d;
         powered_q        <= on_d;
         counters_load_q  <= ~on_d;
         pump_tristate_q  <= ~on_d;
         lock_reset_q     <= ~on_d;
         ref_buf_enable_q <= on_d;
         rf_out_enable_q  <= on_d && !(ctl_q[`SLPC_CTL_MUTE_BIT] && !lock_s);
         pump_gain_select <= gain_q;
         prescaler_sel    <= ctl_q[`SLPC_CTL_PRE_MSB:`SLPC_CTL_PRE_LSB];
         pump_current_a   <= ctl_q[`SLPC_CTL_CURA_MSB:`SLPC_CTL_CURA_LSB];
         pump_current_b   <= ctl_q[`SLPC_CTL_CURB_MSB:`SLPC_CTL_CURB_LSB];
         pump_current     <= gain_q ? ctl_q[`SLPC_CTL_CURB_MSB:`SLPC_CTL_CURB_LSB]
                                    : ctl_q[`SLPC_CTL_CURA_MSB:`SLPC_CTL_CURA_LSB];
         out_level        <= ctl_q[`SLPC_CTL_LVL_MSB:`SLPC_CTL_LVL_LSB];
         mute_until_locked <= ctl_q[`SLPC_CTL_MUTE_BIT];
      end
   end
endmodule // slpc_top

// file: bench/slpc_host.sv
// slpc_host.sv: host model shifting 24-bit words onto the three-wire pins.
// assumes mclk from the bench; pins move on its falling edge.
`timescale 1ns/1ps
module slpc_host (
   input  wire  mclk,
   output logic ser_clk,
   output logic ser_data,
   output logic latch_strobe
);
   initial begin
      ser_clk = 1'b0;
      ser_data = 1'b0;
      latch_strobe = 1'b0;
   end
   // three cycles a phase, above the two that the sync needs
   task automatic send(input logic [23:0] w);
      for (int i = 23; i >= 0; i--) begin
         @(negedge mclk) ser_clk <= 1'b0;
         ser_data <= w[i];
         repeat (3) @(negedge mclk);
         ser_clk <= 1'b1;
         repeat (2) @(negedge mclk);
      end
      @(negedge mclk) ser_clk <= 1'b0;
      ser_data <= ~w[0]; // released line must not hold the last bit
      repeat (3) @(negedge mclk);
      latch_strobe <= 1'b1;
      repeat (6) @(negedge mclk);
      latch_strobe <= 1'b0;
      repeat (6) @(negedge mclk);
   endtask
endmodule // slpc_host

// file: bench/slpc_top_chk.sv
// slpc_top_chk.sv: port checker for the latch and power-down block.
// assumes binding to slpc_top; one clock, async low reset.
`timescale 1ns/1ps
module slpc_top_chk (
   input wire        mclk,
   input wire        nrst,
   input wire        latch_strobe,
   input wire        chip_enable,
   input wire        loop_locked,
   input wire        powered_q,
   input wire        counters_load_q,
   input wire        pump_tristate_q,
   input wire        lock_reset_q,
   input wire        rf_out_enable_q,
   input wire        ref_buf_enable_q,
   input wire        pump_gain_select,
   input wire [13:0] ref_count,
   input wire [2:0]  pump_current_a,
   input wire [2:0]  pump_current_b,
   input wire [2:0]  pump_current,
   input wire        mute_until_locked,
   input wire        divider_written_q
);
   default clocking cb @(posedge mclk); endclocking
   default disable iff (!nrst);
   a_down_outputs_set: assert property (
      !powered_q |-> counters_load_q && pump_tristate_q && lock_reset_q
      && !rf_out_enable_q && !ref_buf_enable_q) else $error("down outputs wrong");
   a_current_follows_gain: assert property (
      $stable(pump_gain_select) && $stable(pump_current_a) && $stable(pump_current_b)
      |-> pump_current == (pump_gain_select ? pump_current_b : pump_current_a))
      else $error("pump current mismatch");
   a_field_load_moment: assert property (
      $changed(ref_count) |-> $past(latch_strobe, 3) && !$past(latch_strobe, 8))
      else $error("ref count changed without strobe");
   a_gain_load_moment: assert property (
      $changed(pump_gain_select) |-> $past(latch_strobe, 3))
      else $error("gain changed without strobe");
   a_div_flag_moment: assert property (
      $rose(divider_written_q) |-> $past(latch_strobe, 3))
      else $error("divider flag without strobe");
   a_div_flag_sticky: assert property (
      divider_written_q |=> divider_written_q) else $error("divider flag dropped");
   a_ce_forces_down: assert property (
      (!chip_enable)[*6] |-> !powered_q) else $error("up with chip enable low");
   a_mute_holds_off: assert property (
      (mute_until_locked && !loop_locked)[*5] |-> !rf_out_enable_q)
      else $error("rf on before lock");
   cover property ($fell(powered_q));
   cover property ($rose(powered_q));
   cover property (!powered_q && $changed(ref_count));
endmodule // slpc_top_chk
bind slpc_top slpc_top_chk slpc_top_chk_inst (.mclk(mclk), .nrst(nrst),
   .latch_strobe(latch_strobe), .chip_enable(chip_enable), .loop_locked(loop_locked),
   .powered_q(powered_q), .counters_load_q(counters_load_q),
   .pump_tristate_q(pump_tristate_q), .lock_reset_q(lock_reset_q),
   .rf_out_enable_q(rf_out_enable_q), .ref_buf_enable_q(ref_buf_enable_q),
   .pump_gain_select(pump_gain_select), .ref_count(ref_count),
   .pump_current_a(pump_current_a), .pump_current_b(pump_current_b),
   .pump_current(pump_current), .mute_until_locked(mute_until_locked),
   .divider_written_q(divider_written_q));

// file: bench/slpc_top_tb.sv
// slpc_top_tb.sv: self-checking bench for slpc_top against a word model.
// assumes slpc_host drives the serial pins; bench drives the rest.
`timescale 1ns/1ps
module slpc_top_tb;
   logic        mclk, nrst, chip_enable, ref_div_out, loop_locked;
   wire         ser_clk, ser_data, latch_strobe, powered_q, counters_load_q;
   wire         pump_tristate_q, lock_reset_q, rf_out_enable_q, ref_buf_enable_q;
   wire         halv_sel, halv_en, pump_gain_select, factory_test_flag;
   wire         lock_precision_sel, mute_until_locked, divider_written_q;
   wire [12:0]  b_count;
   wire [4:0]   a_count;
   wire [1:0]   band_clk_div, antibacklash_width, prescaler_sel, out_level;
   wire [13:0]  ref_count;
   wire [2:0]   pump_current_a, pump_current_b, pump_current;
   logic [23:0] ref_m, ctl_m, div_m;
   logic        gain_m, pwr_m, div_w_m;
   int          seed, fail_count, comparisons, cycles;
   slpc_host slpc_host_inst (.mclk(mclk), .ser_clk(ser_clk), .ser_data(ser_data),
      .latch_strobe(latch_strobe));
   slpc_top slpc_top_inst (.mclk(mclk), .nrst(nrst), .ser_clk(ser_clk), .ser_data(ser_data),
      .latch_strobe(latch_strobe), .chip_enable(chip_enable), .ref_div_out(ref_div_out),
      .loop_locked(loop_locked), .powered_q(powered_q), .counters_load_q(counters_load_q),
      .pump_tristate_q(pump_tristate_q), .lock_reset_q(lock_reset_q),
      .rf_out_enable_q(rf_out_enable_q), .ref_buf_enable_q(ref_buf_enable_q),
      .prescaler_input_halving_sel(halv_sel), .output_halving_enable(halv_en),
      .pump_gain_select(pump_gain_select), .b_count(b_count), .a_count(a_count),
      .band_clk_div(band_clk_div), .factory_test_flag(factory_test_flag),
      .lock_precision_sel(lock_precision_sel), .antibacklash_width(antibacklash_width),
      .ref_count(ref_count), .prescaler_sel(prescaler_sel), .pump_current_a(pump_current_a),
      .pump_current_b(pump_current_b), .pump_current(pump_current), .out_level(out_level),
      .mute_until_locked(mute_until_locked), .divider_written_q(divider_written_q));
   initial begin
      mclk = 1'b0;
      forever #25 mclk = ~mclk;
   end
   task automatic give_verdict;
      $display("comparisons %0d fail_count %0d", comparisons, fail_count);
      if (fail_count == 0 && comparisons > 0) $display("Finished cleanly");
      else $display("Finished with errors");
      $finish;
   endtask
   always @(posedge mclk) begin
      cycles++;
      if (cycles == 40000) begin
         fail_count++;
         give_verdict();
      end
   end
   task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
      comparisons++;
      if (g !== e) begin
         fail_count++;
         $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check_all;
      chk("ref_count", ref_m[15:2], ref_count);
      chk("ref_misc", ref_m[21:16], {band_clk_div, factory_test_flag, lock_precision_sel,
         antibacklash_width});
      chk("a_count", div_m[6:2], a_count);
      chk("b_count", div_m[20:8], b_count);
      chk("halving", div_m[23:22], {halv_sel, halv_en});
      chk("gain", gain_m, pump_gain_select);
      chk("prescaler", ctl_m[23:22], prescaler_sel);
      chk("currents", ctl_m[19:14], {pump_current_b, pump_current_a});
      chk("current", gain_m ? ctl_m[19:17] : ctl_m[16:14], pump_current);
      chk("level", ctl_m[13:11], {out_level, mute_until_locked});
      chk("powered", pwr_m, powered_q);
      chk("down_set", {3{~pwr_m}}, {counters_load_q, pump_tristate_q, lock_reset_q});
      chk("rf_ref", {pwr_m & (~ctl_m[11] | loop_locked), pwr_m},
         {rf_out_enable_q, ref_buf_enable_q});
      chk("div_written", div_w_m, divider_written_q);
   endtask
   task automatic wr(input logic [23:0] w);
      slpc_host_inst.send(w);
      case (w[1:0])
         2'b00: begin
            ctl_m = w;
            gain_m = w[10];
            pwr_m = chip_enable & (~w[20] | (w[21] & pwr_m));
         end
         2'b01: ref_m = w;
         2'b10: begin
            div_m = w;
            gain_m = w[21];
            div_w_m = 1'b1;
         end
         default: ; // test latch leaves all fields alone
      endcase
      check_all();
   endtask
   task automatic ref_pulse;
      @(negedge mclk) ref_div_out = 1'b1;
      repeat (4) @(negedge mclk);
      ref_div_out = 1'b0;
      repeat (4) @(negedge mclk);
   endtask
   // masks keep divider reserved and reference test bits zero, control power bits clear
   function automatic logic [23:0] rnd(input logic [23:0] m, input logic [23:0] s);
      return ($random(seed) & m) | s;
   endfunction
   initial begin
      seed = 32'h1b33;
      {nrst, ref_div_out, ref_m, ctl_m, div_m, gain_m, pwr_m, div_w_m} = '0;
      {chip_enable, loop_locked} = 2'b11;
      repeat (16) @(negedge mclk);
      nrst = 1'b1;
      repeat (3) @(negedge mclk);
      check_all();
      wr(rnd(24'h37FFFC, 24'h000001));
      wr(rnd(24'hCFFFFC, 24'h000000));
      repeat (12000) @(negedge mclk);
      wr(rnd(24'hFFFF7C, 24'h000002));
      for (int i = 0; i < 3; i++) begin
         wr(rnd(24'hCFFFFC, 24'h000000));
         wr(rnd(24'hFFFF7C, 24'h000002));
         wr(rnd(24'hFFFFFF, 24'h000003));
      end
      wr(rnd(24'hCFFFFC, 24'h100000));
      wr(rnd(24'h37FFFC, 24'h000001));
      wr(rnd(24'hCFF7FC, 24'h000000));
      wr(rnd(24'hCFF7FC, 24'h300000));
      ref_pulse();
      chk("sync_first", 1'b1, powered_q);
      ref_pulse();
      pwr_m = 1'b0;
      check_all();
      loop_locked = 1'b0;
      wr(rnd(24'hCFFFFC, 24'h000800));
      loop_locked = 1'b1;
      repeat (6) @(negedge mclk);
      chk("rf_locked", 1'b1, rf_out_enable_q);
      chip_enable = 1'b0;
      repeat (6) @(negedge mclk);
      pwr_m = 1'b0;
      check_all();
      chip_enable = 1'b1;
      repeat (4) @(negedge mclk);
      wr(rnd(24'hCFFFFC, 24'h000000));
      give_verdict();
   end
endmodule // slpc_top_tb
